// ---- hdl/uws_pkg.sv ----
package uws_pkg;
	// Pin sequencing, in cycles of sys_clk (8 ns)
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned SETUP_TIME_NS = 40;
	localparam int unsigned PULSE_TIME_NS = 40;
	localparam int unsigned SETUP_CYC = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PULSE_CYC = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 8;
	// Wiper code space
	localparam int unsigned CODE_W = 6;
	localparam logic [5:0] CODE_MIN = 6'h00;
	localparam logic [5:0] CODE_MAX = 6'h3F;
	localparam logic [5:0] CODE_DEFAULT = 6'h1F;
	localparam int unsigned STEP_W = 7;

	typedef enum logic [5:0] {
		UWS_IDLE = 6'h01,
		UWS_SETUP = 6'h02,
		UWS_SELECT = 6'h04,
		UWS_LOW = 6'h08,
		UWS_HIGH = 6'h10,
		UWS_PARK = 6'h20
	} uws_state_t;
endpackage

// ---- hdl/uws_timer.sv ----
`timescale 1ns/1ps
module uws_timer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Control
	input wire logic load,
	input wire logic [uws_pkg::CNT_W-1:0] load_val,
	// Status
	output logic done
);
	import uws_pkg::*;

	logic [CNT_W-1:0] cnt_reg;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= load_val;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// Load must not feed done: done steers the state decode, which makes load
	assign done = (cnt_reg == '0);
endmodule // uws_timer

// ---- hdl/uws_host.sv ----
`timescale 1ns/1ps
// Operation
// - Host starts every command from idle-high chip select.
// - Host sets step line high before chip select low for increment.
// - Host returns chip select idle promptly after last step.
// - New command may follow chip select return immediately.
// - Host forms no command while supply is below minimum.
module uws_host (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Command request
	input wire logic cmd_valid,
	input wire logic cmd_up,
	input wire logic cmd_hv,
	input wire logic cmd_end_high,
	input wire logic [uws_pkg::STEP_W-1:0] cmd_steps,
	output logic cmd_ready,
	// Supply status
	input wire logic supply_ok,
	input wire logic supply_restored,
	// Device pins
	output logic sel_low,
	output logic select_extra_high_level,
	output logic step_line,
	// Status
	output logic [uws_pkg::CODE_W-1:0] wiper_est,
	output logic busy
);
	import uws_pkg::*;

	uws_state_t state_reg, state_next;
	logic up_reg;
	logic hv_reg;
	logic end_high_reg;
	logic [STEP_W-1:0] left_reg;
	logic tmr_load;
	logic [CNT_W-1:0] tmr_val;
	logic tmr_done;

	uws_timer u_timer (
		.sys_clk(sys_clk),
		.srst(srst),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	// Each phase change reloads the timer
	assign tmr_load = (state_next != state_reg);
	assign tmr_val = (state_next == UWS_LOW || state_next == UWS_HIGH) ?
		CNT_W'(PULSE_CYC) : CNT_W'(SETUP_CYC);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			UWS_IDLE: begin
				// No command while supply is out of range
				if (cmd_valid && supply_ok) begin
					state_next = UWS_SETUP;
				end
			end
			UWS_SETUP: begin
				if (tmr_done) begin
					state_next = UWS_SELECT;
				end
			end
			UWS_SELECT: begin
				if (tmr_done) begin
					state_next = (left_reg == '0) ? UWS_PARK : UWS_LOW;
				end
			end
			UWS_LOW: begin
				if (tmr_done) begin
					state_next = UWS_HIGH;
				end
			end
			UWS_HIGH: begin
				if (tmr_done) begin
					state_next = (left_reg == '0) ? UWS_PARK : UWS_LOW;
				end
			end
			UWS_PARK: begin
				if (tmr_done) begin
					state_next = UWS_IDLE;
				end
			end
			default: begin
				state_next = UWS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg <= UWS_IDLE;
		end else if (!supply_ok) begin
			state_reg <= UWS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Command latch
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			up_reg <= 1'b0;
			hv_reg <= 1'b0;
			end_high_reg <= 1'b0;
			left_reg <= '0;
		end else if (state_reg == UWS_IDLE && cmd_valid && supply_ok) begin
			up_reg <= cmd_up;
			hv_reg <= cmd_hv;
			end_high_reg <= cmd_end_high;
			left_reg <= cmd_steps;
		end else if (state_reg != UWS_HIGH && state_next == UWS_HIGH) begin
			left_reg <= left_reg - 1'b1;
		end
	end

	// Pin drive; every pin comes from a flop
	always_ff @(posedge sys_clk) begin
		if (srst || !supply_ok) begin
			sel_low <= 1'b0;
		end else begin
			case (state_next)
				UWS_SELECT: begin
					sel_low <= !hv_reg;
				end
				UWS_LOW, UWS_HIGH, UWS_PARK: begin
					sel_low <= sel_low;
				end
				default: begin
					sel_low <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || !supply_ok) begin
			select_extra_high_level <= 1'b0;
		end else begin
			case (state_next)
				UWS_SELECT: begin
					select_extra_high_level <= hv_reg;
				end
				UWS_LOW, UWS_HIGH, UWS_PARK: begin
					select_extra_high_level <= select_extra_high_level;
				end
				default: begin
					select_extra_high_level <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || !supply_ok) begin
			step_line <= 1'b0;
		end else begin
			case (state_next)
				UWS_SETUP: begin
					// Direction straight from the request on the taking edge
					step_line <= (state_reg == UWS_IDLE) ? cmd_up : up_reg;
				end
				UWS_SELECT: begin
					step_line <= up_reg;
				end
				UWS_LOW: begin
					step_line <= 1'b0;
				end
				UWS_HIGH: begin
					step_line <= 1'b1;
				end
				UWS_PARK: begin
					// A rise while selected counts as one more step, so parking may only fall
					step_line <= end_high_reg && step_line;
				end
				default: begin
					step_line <= step_line;
				end
			endcase
		end
	end

	// Host-side copy of the volatile wiper, since it cannot be read back
	always_ff @(posedge sys_clk) begin
		if (srst || supply_restored) begin
			wiper_est <= CODE_DEFAULT;
		end else if (state_reg != UWS_HIGH && state_next == UWS_HIGH && supply_ok) begin
			if (up_reg && wiper_est != CODE_MAX) begin
				wiper_est <= wiper_est + 1'b1;
			end else if (!up_reg && wiper_est != CODE_MIN) begin
				wiper_est <= wiper_est - 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy <= 1'b0;
		end else begin
			busy <= (state_next != UWS_IDLE) && supply_ok;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cmd_ready <= 1'b0;
		end else begin
			cmd_ready <= (state_next == UWS_IDLE) && supply_ok;
		end
	end
endmodule // uws_host

// ---- bench/uws_dev_model.sv ----
`timescale 1ns/1ps
module uws_dev_model (
	// Device pins
	input logic sel_low,
	input logic select_extra_high_level,
	input logic step_line,
	input logic por,
	// Bench view only, the host cannot read it
	output logic [5:0] wiper
);
	logic up, act;
	assign act = sel_low || select_extra_high_level;
	// Volatile: nothing keeps the code across a supply loss
	initial wiper = 6'h1F;
	always @(posedge act) up = step_line;
	always @(posedge step_line or posedge por) begin
		if (por) wiper = 6'h1F;
		else if (act && up && wiper != 6'h3F) wiper = wiper + 6'h01;
		else if (act && !up && wiper != 6'h00) wiper = wiper - 6'h01;
	end
endmodule // uws_dev_model

// ---- bench/uws_host_chk.sv ----
`timescale 1ns/1ps
module uws_host_chk (
	// Clock and reset
	input logic sys_clk,
	input logic srst,
	// Watched
	input logic busy,
	input logic [uws_pkg::CODE_W-1:0] wiper_est,
	input logic supply_ok,
	input logic supply_restored,
	input logic sel_low,
	input logic select_extra_high_level,
	input logic step_line
);
	import uws_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic sel, ld, pw_ok;
	logic [5:0] pw;
	assign sel = sel_low || select_extra_high_level;
	assign ld = supply_restored || srst;
	// One step up below the top or one step down above the bottom, never a wrap
	assign pw_ok = (wiper_est == pw + 6'h01 && pw != CODE_MAX) ||
		(wiper_est == pw - 6'h01 && pw != CODE_MIN);
	always_ff @(posedge sys_clk) pw <= wiper_est;
	AST_BOTH: assert property (!(sel_low && select_extra_high_level))
		else $error("both selects");
	AST_DIR: assert property ($rose(sel) |-> $stable(step_line))
		else $error("direction moved");
	AST_SUP: assert property (!supply_ok |=> !busy && !sel)
		else $error("no abort");
	AST_STEP: assert property ($changed(wiper_est) && !$past(ld) |-> $rose(step_line))
		else $error("move off edge");
	AST_ONE: assert property ($changed(wiper_est) && !$past(ld) |-> sel)
		else $error("move unselected");
	AST_IGN: assert property ($rose(step_line) && !$past(sel) && !$past(ld) |-> $stable(wiper_est))
		else $error("idle step");
	AST_WRAP: assert property ($changed(wiper_est) && !$past(ld) |-> pw_ok)
		else $error("bad step");
	AST_RST: assert property (supply_restored |=> wiper_est == CODE_DEFAULT)
		else $error("no default");
	cover property ($rose(sel_low));
	cover property ($rose(select_extra_high_level));
	cover property (wiper_est == CODE_MAX && $rose(step_line));
endmodule // uws_host_chk
bind uws_host uws_host_chk uws_host_chk_i (.sys_clk, .srst, .busy, .wiper_est, .supply_ok,
	.supply_restored, .sel_low, .select_extra_high_level, .step_line);

// ---- bench/uws_host_bench.sv ----
`timescale 1ns/1ps
module uws_host_bench;
	import uws_pkg::*;
	logic sys_clk = 0, srst = 1, cmd_valid = 0, cmd_up = 0, cmd_hv = 0, cmd_end_high = 0;
	logic [STEP_W-1:0] cmd_steps = '0;
	logic supply_ok = 1, supply_restored = 0;
	logic cmd_ready, sel_low, select_extra_high_level, step_line, busy;
	logic [CODE_W-1:0] wiper_est, wiper, exp_w;
	int error_cnt = 0, n_tests = 0;
	always #4 sys_clk = ~sys_clk;
	uws_host uws_host_i (.sys_clk, .srst, .cmd_valid, .cmd_up, .cmd_hv, .cmd_end_high,
		.cmd_steps, .cmd_ready, .supply_ok, .supply_restored, .sel_low,
		.select_extra_high_level, .step_line, .wiper_est, .busy);
	uws_dev_model uws_dev_model_i (.sel_low, .select_extra_high_level, .step_line,
		.por(supply_restored), .wiper);
	task automatic fail(input string m);
		error_cnt++;
		$display("MISMATCH at %0t: %s", $time, m);
	endtask
	task automatic check;
		n_tests += 2;
		if (wiper_est !== exp_w) fail("estimate");
		if (wiper !== exp_w) fail("device wiper");
	endtask
	task automatic run_cmd(input logic u, h, e, input logic [STEP_W-1:0] s);
		@(negedge sys_clk);
		{cmd_up, cmd_hv, cmd_end_high, cmd_steps, cmd_valid} = {u, h, e, s, 1'b1};
		// Hold the request until busy shows that the edge before took it
		do @(negedge sys_clk); while (busy !== 1'b1);
		cmd_valid = 0;
		for (int i = 0; i < s; i++) exp_w = u ? exp_w + (exp_w != CODE_MAX) : exp_w - (exp_w != CODE_MIN);
		for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge sys_clk);
		n_tests += 2;
		if (busy !== 1'b0) fail("busy stuck");
		if (cmd_ready !== 1'b1) fail("not ready after command");
		check;
	endtask
	task automatic t_reset;
		repeat (10) @(negedge sys_clk);
		srst = 0;
		exp_w = CODE_DEFAULT;
		@(negedge sys_clk);
		n_tests++;
		if (cmd_ready !== 1'b1 || busy !== 1'b0 || sel_low !== 1'b0) fail("reset state");
		check;
		$display("reset done");
	endtask
	task automatic t_commands;
		for (int c = 0; c < 8; c++) run_cmd(c[2], c[1], c[0], 7'h03);
		$display("command set done");
	endtask
	task automatic t_ends;
		run_cmd(1'b1, 1'b0, 1'b0, 7'h7F);
		run_cmd(1'b0, 1'b0, 1'b1, 7'h00);
		run_cmd(1'b0, 1'b1, 1'b1, 7'h7F);
		run_cmd(1'b1, 1'b0, 1'b0, 7'h00);
		$display("end stops done");
	endtask
	task automatic t_brownout;
		@(negedge sys_clk);
		{cmd_up, cmd_steps, cmd_valid} = {1'b1, 7'h05, 1'b1};
		@(negedge sys_clk);
		{cmd_valid, supply_ok} = 2'b00;
		@(negedge sys_clk);
		n_tests++;
		if (busy !== 1'b0 || sel_low !== 1'b0 || cmd_ready !== 1'b0 || step_line !== 1'b0) fail("no abort");
		{supply_ok, supply_restored} = 2'b11;
		@(negedge sys_clk);
		supply_restored = 0;
		exp_w = CODE_DEFAULT;
		check;
		run_cmd(1'b0, 1'b0, 1'b0, 7'h02);
		$display("brown-out done");
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		t_reset;
		t_commands;
		t_ends;
		t_brownout;
		give_verdict;
	end
	initial begin
		#160000;
		fail("timeout");
		give_verdict;
	end
endmodule // uws_host_bench
